// File: hw/itfd_decoder.v
// Operation
// - Same function on two terminals is rejected; code zero may repeat.
// - Run and jog functions act only with terminal command source.
// - Jog ignored while running; run ignored while jogging.
// - Three-wire control acts only with terminal command source.
// - Speed-select terminals honoured only with multi-speed main source.
// - Speed bits form index 0 to 15, bit four most significant.
// - Single motor: two ramp terminals pick ramp set 1 to 4.
// - Motor switch: terminal 2 picks set 3 or 4; terminal 1 is ignored.
// - Up/down terminals step reference when main or aux source is digital.
// - Open or closed external fault input latches fault with its code.
// - Source switch selects aux while closed, only for combination 0 or 1.
// - Combination 2 to 5: terminals force main or aux reference.
// - Reset terminal clears faults only under terminal command control.
// - Coast-stop terminal while running removes output at once.
// - Ramp hold freezes frequency except during a stop command.
// - Stop braking below threshold, lasting longer of hold and set time.
// - PLC pause runs zero frequency, freezes timer, resumes with tracking.
// - Memory-clear terminal clears stored PLC state when stopped in PLC.
// - PID pause disables PID output, forcing zero frequency.
// - Integral hold freezes PID integral while closed.
// - Three select bits choose main channel; latest change prevails.
// - Override terminals set command source; release restores setting.
`timescale 1ns/1ps
`include "itfd_defs.vh"

module itfd_decoder #(
    parameter TICK_CYCLES = `ITFD_TICK_NS / `ITFD_CLK_PERIOD_NS
) (
    input wire clk,
    input wire reset,
    input wire [`ITFD_NUM_TERM-1:0] terminal_in,
    input wire [`ITFD_NUM_TERM*`ITFD_FUNC_W-1:0] terminal_function,
    input wire [1:0] run_command_source_setting,
    input wire [1:0] communication_type_setting,
    input wire [3:0] main_reference_source_setting,
    input wire [3:0] auxiliary_reference_source_setting,
    input wire [2:0] reference_combination_setting,
    input wire [3:0] main_channel_default_setting,
    input wire [15:0] updown_rate_setting,
    input wire [15:0] stop_braking_start_frequency,
    input wire [15:0] stop_braking_current,
    input wire [15:0] stop_braking_time,
    input wire [15:0] running_frequency,
    input wire running_state,
    input wire jog_state,
    input wire stop_command,
    input wire plc_mode_stopped,
    output reg config_error,
    output reg fwd_run,
    output reg rev_run,
    output reg fwd_jog,
    output reg rev_jog,
    output reg three_wire_enable,
    output reg preset_speed_valid,
    output reg [3:0] preset_speed_index,
    output reg [1:0] ramp_set,
    output reg [15:0] updown_offset,
    output reg external_fault,
    output reg [7:0] external_fault_code,
    output reg fault_reset,
    output reg use_auxiliary_reference,
    output reg force_main_reference,
    output reg force_auxiliary_reference,
    output reg coast_stop,
    output reg ramp_hold,
    output reg dc_brake_active,
    output reg [15:0] dc_brake_current,
    output reg plc_pause,
    output reg plc_resume_tracking,
    output reg plc_memory_clear,
    output reg pid_pause,
    output reg pid_integral_hold,
    output reg [3:0] main_channel,
    output reg [1:0] command_source,
    output reg [1:0] communication_type
);

    localparam NT = `ITFD_NUM_TERM;
    localparam FW = `ITFD_FUNC_W;
    localparam VW = `ITFD_FN_VEC_W;

    reg [NT-1:0] sync1;
    reg [NT-1:0] sync2;
    reg [NT-1:0] sync3;
    reg [NT-1:0] stable;
    wire [VW-1:0] term_hot [0:NT-1];
    reg [VW-1:0] fn;
    reg dup;
    reg fn_nc_assigned;
    reg fn_nc_level;
    integer i;
    integer j;
    integer k;

    // Three-stage sampler; a change counts once stages two and three agree
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1 <= {NT{1'b0}};
            sync2 <= {NT{1'b0}};
            sync3 <= {NT{1'b0}};
            stable <= {NT{1'b0}};
        end else begin
            sync1 <= terminal_in;
            sync2 <= sync1;
            sync3 <= sync2;
            stable <= (sync2 & sync3) | (stable & (sync2 ^ sync3));
        end
    end

    // Per terminal one-hot of its function while the terminal is active
    genvar t;
    generate
        for (t = 0; t < NT; t = t + 1) begin : g_term
            wire [FW-1:0] code = terminal_function[t*FW +: FW];
            assign term_hot[t] = stable[t] ? ({{(VW-1){1'b0}}, 1'b1} << code)
                                           : {VW{1'b0}};
        end
    endgenerate

    // Duplicate detection and function vector merge
    always @* begin
        dup = 1'b0;
        fn = {VW{1'b0}};
        for (i = 0; i < NT; i = i + 1) begin
            fn = fn | term_hot[i];
            for (j = i + 1; j < NT; j = j + 1) begin
                if (terminal_function[i*FW +: FW] ==
                    terminal_function[j*FW +: FW] &&
                    terminal_function[i*FW +: FW] != `ITFD_FN_NONE) begin
                    dup = 1'b1;
                end
            end
        end
        if (dup) begin
            fn = {VW{1'b0}};
        end
    end

    // Effective command source with override priority
    reg [1:0] next_source;
    always @* begin
        if (fn[`ITFD_FN_CMD_KEYPAD]) begin
            next_source = `ITFD_SRC_KEYPAD;
        end else if (fn[`ITFD_FN_CMD_TERMINAL]) begin
            next_source = `ITFD_SRC_TERMINAL;
        end else if (fn[`ITFD_FN_CMD_COMM]) begin
            next_source = `ITFD_SRC_COMM;
        end else begin
            next_source = run_command_source_setting;
        end
    end

    wire src_term = (next_source == `ITFD_SRC_TERMINAL);
    wire ext_fault_in = fn[`ITFD_FN_EXT_FAULT_NO] |
                        (fn_nc_assigned & ~fn_nc_level);
    wire comb_ab = (reference_combination_setting <= `ITFD_COMB_MAX_AB);
    wire comb_mix = (reference_combination_setting >= `ITFD_COMB_LOW) &&
                    (reference_combination_setting <= `ITFD_COMB_HIGH);
    wire [2:0] sel_idx = {fn[`ITFD_FN_MAIN_SEL3], fn[`ITFD_FN_MAIN_SEL2],
                          fn[`ITFD_FN_MAIN_SEL1]};

    // Normally-closed fault: active while its terminal is open
    always @* begin
        fn_nc_assigned = 1'b0;
        fn_nc_level = 1'b0;
        for (k = 0; k < NT; k = k + 1) begin
            if (terminal_function[k*FW +: FW] == `ITFD_FN_EXT_FAULT_NC) begin
                fn_nc_assigned = ~dup;
                fn_nc_level = stable[k];
            end
        end
    end

    // Decoded command and selection outputs
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            config_error <= 1'b0;
            fwd_run <= 1'b0;
            rev_run <= 1'b0;
            fwd_jog <= 1'b0;
            rev_jog <= 1'b0;
            three_wire_enable <= 1'b0;
            preset_speed_valid <= 1'b0;
            preset_speed_index <= 4'h0;
            ramp_set <= 2'h0;
            fault_reset <= 1'b0;
            use_auxiliary_reference <= 1'b0;
            force_main_reference <= 1'b0;
            force_auxiliary_reference <= 1'b0;
            coast_stop <= 1'b0;
            ramp_hold <= 1'b0;
            plc_pause <= 1'b0;
            plc_resume_tracking <= 1'b0;
            plc_memory_clear <= 1'b0;
            pid_pause <= 1'b0;
            pid_integral_hold <= 1'b0;
            command_source <= `ITFD_SRC_KEYPAD;
            communication_type <= 2'h0;
        end else begin
            config_error <= dup;
            fwd_run <= fn[`ITFD_FN_FWD_RUN] & src_term & ~jog_state;
            rev_run <= fn[`ITFD_FN_REV_RUN] & src_term & ~jog_state;
            fwd_jog <= fn[`ITFD_FN_FWD_JOG] & src_term & ~running_state;
            rev_jog <= fn[`ITFD_FN_REV_JOG] & src_term & ~running_state;
            three_wire_enable <= fn[`ITFD_FN_THREE_WIRE] & src_term;
            preset_speed_valid <= (main_reference_source_setting ==
                                   `ITFD_REF_MULTI_SPEED);
            if (main_reference_source_setting == `ITFD_REF_MULTI_SPEED) begin
                preset_speed_index <= {fn[`ITFD_FN_SPEED_B4],
                                       fn[`ITFD_FN_SPEED_B3],
                                       fn[`ITFD_FN_SPEED_B2],
                                       fn[`ITFD_FN_SPEED_B1]};
            end else begin
                preset_speed_index <= 4'h0;
            end
            // Ramp set as 0..3 meaning set 1..4
            if (fn[`ITFD_FN_MOTOR_SWITCH]) begin
                ramp_set <= {1'b1, fn[`ITFD_FN_RAMP_T2]};
            end else begin
                ramp_set <= {fn[`ITFD_FN_RAMP_T2], fn[`ITFD_FN_RAMP_T1]};
            end
            fault_reset <= fn[`ITFD_FN_FAULT_RESET] & src_term;
            use_auxiliary_reference <= fn[`ITFD_FN_SRC_A_TO_B] & comb_ab;
            force_main_reference <= fn[`ITFD_FN_COMB_TO_MAIN] & comb_mix;
            force_auxiliary_reference <= fn[`ITFD_FN_COMB_TO_AUX] & comb_mix &
                                         ~fn[`ITFD_FN_COMB_TO_MAIN];
            coast_stop <= fn[`ITFD_FN_COAST_STOP] & running_state;
            ramp_hold <= fn[`ITFD_FN_RAMP_HOLD] & ~stop_command;
            plc_pause <= fn[`ITFD_FN_PLC_PAUSE];
            plc_resume_tracking <= plc_pause & ~fn[`ITFD_FN_PLC_PAUSE];
            plc_memory_clear <= fn[`ITFD_FN_PLC_MEM_CLR] & plc_mode_stopped;
            pid_pause <= fn[`ITFD_FN_PID_PAUSE];
            pid_integral_hold <= fn[`ITFD_FN_PID_INT_HOLD];
            command_source <= next_source;
            communication_type <= communication_type_setting;
        end
    end

    // External fault latch; a new fault wins over a reset
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            external_fault <= 1'b0;
            external_fault_code <= 8'h00;
        end else if (ext_fault_in) begin
            external_fault <= 1'b1;
            external_fault_code <= `ITFD_EXT_FAULT_CODE;
        end else if (fn[`ITFD_FN_FAULT_RESET] & src_term) begin
            external_fault <= 1'b0;
            external_fault_code <= 8'h00;
        end
    end

    // Main channel: latest change of terminal index or setting wins
    reg [2:0] last_idx;
    reg [3:0] last_setting;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            last_idx <= 3'h0;
            last_setting <= 4'h0;
            main_channel <= 4'h0;
        end else begin
            last_idx <= sel_idx;
            last_setting <= main_channel_default_setting;
            if (sel_idx != last_idx) begin
                if (sel_idx == 3'h0) begin
                    main_channel <= main_channel_default_setting;
                end else begin
                    main_channel <= {1'b0, sel_idx};
                end
            end else if (main_channel_default_setting != last_setting) begin
                main_channel <= main_channel_default_setting;
            end
        end
    end

    // Base tick for up/down rate and braking time
    reg [17:0] tick_cnt;
    reg tick;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_cnt <= 18'h00000;
            tick <= 1'b0;
        end else if (tick_cnt == TICK_CYCLES[17:0] - 18'h00001) begin
            tick_cnt <= 18'h00000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 18'h00001;
            tick <= 1'b0;
        end
    end

    // Up/down reference offset, saturating, stepped once per tick
    wire updn_ok = (main_reference_source_setting == `ITFD_REF_DIGITAL) ||
                   (auxiliary_reference_source_setting == `ITFD_REF_DIGITAL);
    wire [16:0] up_sum = {1'b0, updown_offset} + {1'b0, updown_rate_setting};
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            updown_offset <= 16'h0000;
        end else if (fn[`ITFD_FN_UPDN_CLR] | fn[`ITFD_FN_UPDN_CLR_KP]) begin
            updown_offset <= 16'h0000;
        end else if (tick & updn_ok) begin
            if (fn[`ITFD_FN_FREQ_UP] & ~fn[`ITFD_FN_FREQ_DOWN]) begin
                updown_offset <= up_sum[16] ? 16'hffff : up_sum[15:0];
            end else if (fn[`ITFD_FN_FREQ_DOWN] & ~fn[`ITFD_FN_FREQ_UP]) begin
                updown_offset <= (updown_offset > updown_rate_setting) ?
                    updown_offset - updown_rate_setting : 16'h0000;
            end
        end
    end

    // DC braking at stop
    localparam BRK_IDLE = `ITFD_BRK_IDLE;
    localparam BRK_ARMED = `ITFD_BRK_ARMED;
    localparam BRK_ACTIVE = `ITFD_BRK_ACTIVE;
    reg [2:0] brk_state;
    reg [15:0] brk_elapsed;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            brk_state <= BRK_IDLE;
            brk_elapsed <= 16'h0000;
            dc_brake_active <= 1'b0;
            dc_brake_current <= 16'h0000;
        end else begin
            case (brk_state)
                BRK_IDLE: begin
                    if (stop_command & fn[`ITFD_FN_DC_BRAKE]) begin
                        brk_state <= BRK_ARMED;
                    end
                end
                BRK_ARMED: begin
                    if (~stop_command) begin
                        brk_state <= BRK_IDLE;
                    end else if (running_frequency <
                                 stop_braking_start_frequency) begin
                        brk_state <= BRK_ACTIVE;
                        brk_elapsed <= 16'h0000;
                        dc_brake_active <= 1'b1;
                        dc_brake_current <= stop_braking_current;
                    end
                end
                BRK_ACTIVE: begin
                    if (tick && brk_elapsed != 16'hffff) begin
                        brk_elapsed <= brk_elapsed + 16'h0001;
                    end
                    if (brk_elapsed >= stop_braking_time &&
                        ~fn[`ITFD_FN_DC_BRAKE]) begin
                        brk_state <= BRK_IDLE;
                        dc_brake_active <= 1'b0;
                        dc_brake_current <= 16'h0000;
                    end
                end
                default: begin
                    brk_state <= BRK_IDLE;
                    dc_brake_active <= 1'b0;
                end
            endcase
        end
    end

endmodule // itfd_decoder

// File: pkg/itfd_defs.vh
`ifndef ITFD_DEFS_VH
`define ITFD_DEFS_VH

// Terminal count and function code width
`define ITFD_NUM_TERM 8
`define ITFD_FUNC_W 7
`define ITFD_FN_VEC_W 64

// Terminal function codes
`define ITFD_FN_NONE 0
`define ITFD_FN_FWD_RUN 1
`define ITFD_FN_REV_RUN 2
`define ITFD_FN_FWD_JOG 3
`define ITFD_FN_REV_JOG 4
`define ITFD_FN_THREE_WIRE 5
`define ITFD_FN_SPEED_B1 6
`define ITFD_FN_SPEED_B2 7
`define ITFD_FN_SPEED_B3 8
`define ITFD_FN_SPEED_B4 9
`define ITFD_FN_RAMP_T1 10
`define ITFD_FN_RAMP_T2 11
`define ITFD_FN_UPDN_CLR 12
`define ITFD_FN_UPDN_CLR_KP 13
`define ITFD_FN_FREQ_UP 14
`define ITFD_FN_FREQ_DOWN 15
`define ITFD_FN_EXT_FAULT_NO 16
`define ITFD_FN_EXT_FAULT_NC 17
`define ITFD_FN_SRC_A_TO_B 20
`define ITFD_FN_COMB_TO_MAIN 21
`define ITFD_FN_FAULT_RESET 22
`define ITFD_FN_COAST_STOP 23
`define ITFD_FN_RAMP_HOLD 24
`define ITFD_FN_DC_BRAKE 25
`define ITFD_FN_PLC_PAUSE 26
`define ITFD_FN_COMB_TO_AUX 27
`define ITFD_FN_PLC_MEM_CLR 28
`define ITFD_FN_PID_PAUSE 29
`define ITFD_FN_PID_INT_HOLD 31
`define ITFD_FN_MAIN_SEL1 34
`define ITFD_FN_MAIN_SEL2 35
`define ITFD_FN_MAIN_SEL3 36
`define ITFD_FN_CMD_KEYPAD 38
`define ITFD_FN_CMD_TERMINAL 39
`define ITFD_FN_CMD_COMM 40
`define ITFD_FN_MOTOR_SWITCH 55

// Setting values
`define ITFD_SRC_KEYPAD 2'h0
`define ITFD_SRC_TERMINAL 2'h1
`define ITFD_SRC_COMM 2'h2
`define ITFD_REF_DIGITAL 4'h0
`define ITFD_REF_MULTI_SPEED 4'h5
`define ITFD_COMB_MAX_AB 3'h1
`define ITFD_COMB_LOW 3'h2
`define ITFD_COMB_HIGH 3'h5

// Main channel codes, terminal index 1 to 7
`define ITFD_CH_ANALOG1 4'h1
`define ITFD_CH_ANALOG2 4'h2
`define ITFD_CH_PULSE 4'h3
`define ITFD_CH_PLC 4'h4
`define ITFD_CH_MULTI_SPEED 4'h5
`define ITFD_CH_PID 4'h6
`define ITFD_CH_MODBUS 4'h7

// External fault code (value arbitrary)
`define ITFD_EXT_FAULT_CODE 8'h2a

// Timing: base tick for up/down rate and braking time
`define ITFD_CLK_PERIOD_NS 5
`define ITFD_TICK_NS 1000000

// Braking state codes, one-hot
`define ITFD_BRK_IDLE 3'h1
`define ITFD_BRK_ARMED 3'h2
`define ITFD_BRK_ACTIVE 3'h4

`endif

// File: test/itfd_decoder_tb.sv
`timescale 1ns/1ps
`include "itfd_defs.vh"
module itfd_decoder_tb;
    reg clk, reset, running_state, jog_state, stop_command, plc_mode_stopped;
    reg [7:0] sw;
    reg [55:0] terminal_function;
    reg [1:0] run_command_source_setting, communication_type_setting;
    reg [3:0] main_reference_source_setting, main_channel_default_setting;
    reg [3:0] auxiliary_reference_source_setting;
    reg [2:0] reference_combination_setting;
    reg [15:0] updown_rate_setting, stop_braking_start_frequency;
    reg [15:0] stop_braking_current, stop_braking_time, running_frequency;
    wire [7:0] terminal_in;
    wire config_error, fwd_run, rev_run, fwd_jog, rev_jog, three_wire_enable;
    wire preset_speed_valid, external_fault, fault_reset, coast_stop;
    wire use_auxiliary_reference, force_main_reference, ramp_hold;
    wire force_auxiliary_reference, dc_brake_active, plc_pause, pid_pause;
    wire plc_resume_tracking, plc_memory_clear, pid_integral_hold;
    wire [3:0] preset_speed_index, main_channel;
    wire [1:0] ramp_set, command_source, communication_type;
    wire [15:0] updown_offset, dc_brake_current;
    wire [7:0] external_fault_code;
    wire [4:0] cmd = {fwd_run, rev_run, three_wire_enable, fwd_jog, rev_jog};
    wire [5:0] lvl = {pid_integral_hold, pid_pause, plc_memory_clear,
        plc_pause, ramp_hold, coast_stop};
    localparam [41:0] LVL = {7'h1f, 7'h1d, 7'h1c, 7'h1a, 7'h18, 7'h17};
    integer n_fail, samples_checked, i;

    itfd_switches i_sw (.clk(clk), .want(sw), .terminal_in(terminal_in));
    itfd_decoder #(.TICK_CYCLES(8)) i_dut (.*);

    // Free-running 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task end_sim;
        begin
            $display("checked %0d failed %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task chk(input [16:0] got, input [16:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task fn(input integer t, input [6:0] c);
        terminal_function[7*t +: 7] = c;
    endtask

    // Covers sampler delay and one output edge
    task st;
        repeat (8) @(negedge clk);
    endtask

    // Watchdog against a hang
    initial begin
        #60000;
        n_fail = n_fail + 1;
        end_sim;
    end

    // Stimulus and checks, all driven at the falling edge
    initial begin
        n_fail = 0;
        samples_checked = 0;
        {reset, sw, terminal_function} = {1'b1, 64'h0};
        {running_state, jog_state, stop_command, plc_mode_stopped} = 4'h0;
        run_command_source_setting = 2'h0;
        communication_type_setting = 2'h0;
        main_reference_source_setting = 4'h0;
        auxiliary_reference_source_setting = 4'h5;
        reference_combination_setting = 3'h0;
        main_channel_default_setting = 4'h8;
        updown_rate_setting = 16'h0001;
        stop_braking_start_frequency = 16'h0064;
        stop_braking_current = 16'h0033;
        stop_braking_time = 16'h0002;
        running_frequency = 16'h0000;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        chk(command_source, 0);
        fn(0, `ITFD_FN_FWD_RUN);
        fn(1, `ITFD_FN_FWD_RUN);
        st;
        chk(config_error, 1);
        fn(1, `ITFD_FN_NONE);
        fn(2, `ITFD_FN_NONE);
        st;
        chk(config_error, 0);
        fn(1, `ITFD_FN_THREE_WIRE);
        fn(2, `ITFD_FN_FWD_JOG);
        fn(3, `ITFD_FN_REV_RUN);
        fn(4, `ITFD_FN_REV_JOG);
        run_command_source_setting = 2'h1;
        sw = 8'h1f;
        st;
        chk(cmd, 5'h1f);
        running_state = 1'b1;
        st;
        chk(cmd, 5'h1c);
        {running_state, jog_state} = 2'h1;
        st;
        chk(cmd, 5'h07);
        {jog_state, run_command_source_setting} = 3'h0;
        st;
        chk(cmd, 5'h00);
        terminal_function = 56'h0;
        for (i = 0; i < 4; i = i + 1)
            fn(i, `ITFD_FN_SPEED_B1 + i);
        main_reference_source_setting = 4'h5;
        for (i = 0; i < 16; i = i + 1) begin
            sw = i[7:0];
            st;
            chk({preset_speed_valid, preset_speed_index}, 16 + i);
        end
        main_reference_source_setting = 4'h0;
        st;
        chk(preset_speed_valid, 0);
        fn(4, `ITFD_FN_RAMP_T1);
        fn(5, `ITFD_FN_RAMP_T2);
        fn(6, `ITFD_FN_MOTOR_SWITCH);
        for (i = 0; i < 8; i = i + 1) begin
            sw = {1'b0, i[2:0], 4'h0};
            st;
            chk(ramp_set, i[2] ? {1'b1, i[1]} : i[1:0]);
        end
        sw = 8'h02; // Close the NC contact before it gets its function
        st;
        terminal_function = 56'h0;
        fn(0, `ITFD_FN_EXT_FAULT_NO);
        fn(1, `ITFD_FN_EXT_FAULT_NC);
        fn(2, `ITFD_FN_FAULT_RESET);
        st;
        chk(external_fault, 0);
        sw = 8'h03;
        st;
        chk({external_fault, external_fault_code}, 9'h12a);
        sw = 8'h06;
        st;
        chk(external_fault, 1);
        run_command_source_setting = 2'h1;
        st;
        chk({external_fault, fault_reset}, 2'h1);
        sw = 8'h00;
        st;
        chk(external_fault, 1);
        sw = 8'h06;
        st;
        chk(external_fault, 0);
        terminal_function = 56'h0;
        fn(0, `ITFD_FN_FREQ_UP);
        fn(1, `ITFD_FN_UPDN_CLR);
        main_reference_source_setting = 4'h5;
        sw = 8'h01;
        repeat (40) @(negedge clk);
        chk(updown_offset, 0);
        auxiliary_reference_source_setting = 4'h0;
        repeat (40) @(negedge clk);
        chk(updown_offset > 16'h2, 1);
        sw = 8'h02;
        st;
        chk(updown_offset, 0);
        fn(0, `ITFD_FN_SRC_A_TO_B);
        fn(1, `ITFD_FN_COMB_TO_MAIN);
        fn(2, `ITFD_FN_COMB_TO_AUX);
        sw = 8'h01;
        st;
        chk(use_auxiliary_reference, 1);
        reference_combination_setting = 3'h3;
        st;
        chk(use_auxiliary_reference, 0);
        for (i = 2; i < 8; i = i + 2) begin
            sw = i[7:0];
            st;
            chk({force_main_reference, force_auxiliary_reference},
                (i == 4) ? 1 : 2);
        end
        reference_combination_setting = 3'h1;
        st;
        chk(force_main_reference, 0);
        for (i = 0; i < 3; i = i + 1)
            fn(i, `ITFD_FN_MAIN_SEL1 + i);
        for (i = 1; i < 9; i = i + 1) begin
            sw = i[2:0];
            st;
            chk(main_channel, (i == 8) ? 8 : i);
        end
        sw = 8'h05;
        st;
        main_channel_default_setting = 4'hc;
        st;
        chk(main_channel, 4'hc);
        for (i = 0; i < 3; i = i + 1)
            fn(i, `ITFD_FN_CMD_KEYPAD + i);
        communication_type_setting = 2'h3;
        for (i = 4; i < 8; i = i + 1) begin
            sw = (i == 7) ? 8'h00 : i[7:0];
            st;
            chk({command_source, communication_type},
                (i == 4) ? 4'hb : (i == 5) ? 4'h3 : 4'h7);
        end
        {running_state, plc_mode_stopped} = 2'h3;
        for (i = 0; i < 6; i = i + 1) begin
            terminal_function = 56'h0;
            fn(0, LVL[7*i +: 7]);
            sw = 8'h01;
            st;
            chk(lvl[i], 1);
            sw = 8'h00;
            st;
            chk(lvl[i], 0);
        end
        fn(0, `ITFD_FN_RAMP_HOLD);
        {running_state, stop_command, sw} = {2'h1, 8'h01};
        st;
        chk(ramp_hold, 0);
        fn(0, `ITFD_FN_DC_BRAKE);
        running_frequency = 16'h01f4;
        st;
        chk(dc_brake_active, 0);
        running_frequency = 16'h0032;
        st;
        chk({dc_brake_active, dc_brake_current}, 17'h10033);
        repeat (40) @(negedge clk);
        chk(dc_brake_active, 1);
        sw = 8'h00;
        st;
        chk(dc_brake_active, 0);
        stop_braking_time = 16'h0008;
        sw = 8'h01;
        st;
        sw = 8'h00;
        st;
        chk(dc_brake_active, 1);
        repeat (80) @(negedge clk);
        chk(dc_brake_active, 0);
        end_sim;
    end
endmodule // itfd_decoder_tb

bind itfd_decoder itfd_props i_props (.*);

// File: test/itfd_props.sv
`timescale 1ns/1ps
`include "itfd_defs.vh"
module itfd_props (
    input wire clk,
    input wire reset,
    input wire [3:0] main_reference_source_setting,
    input wire [3:0] auxiliary_reference_source_setting,
    input wire [2:0] reference_combination_setting,
    input wire [15:0] stop_braking_start_frequency,
    input wire [15:0] stop_braking_current,
    input wire [15:0] running_frequency,
    input wire config_error,
    input wire fwd_run,
    input wire rev_run,
    input wire preset_speed_valid,
    input wire [15:0] updown_offset,
    input wire external_fault,
    input wire [7:0] external_fault_code,
    input wire use_auxiliary_reference,
    input wire force_main_reference,
    input wire force_auxiliary_reference,
    input wire dc_brake_active,
    input wire [15:0] dc_brake_current,
    input wire plc_pause,
    input wire plc_resume_tracking
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Decode relations between settings and outputs
    property p_cfg;
        config_error [*3] |-> !fwd_run && !rev_run;
    endproperty
    property p_code;
        external_fault |-> external_fault_code == `ITFD_EXT_FAULT_CODE;
    endproperty
    property p_spd;
        preset_speed_valid && $stable(main_reference_source_setting)
            |-> main_reference_source_setting == 4'h5;
    endproperty
    property p_upd;
        $changed(updown_offset) && updown_offset != 16'h0
            && $stable(main_reference_source_setting)
            && $stable(auxiliary_reference_source_setting)
            |-> main_reference_source_setting == 4'h0
            || auxiliary_reference_source_setting == 4'h0;
    endproperty
    property p_aux;
        use_auxiliary_reference && $stable(reference_combination_setting)
            |-> reference_combination_setting <= 3'h1;
    endproperty
    property p_fmain;
        force_main_reference && $stable(reference_combination_setting)
            |-> reference_combination_setting inside {[3'h2:3'h5]};
    endproperty
    property p_both;
        force_main_reference |-> !force_auxiliary_reference;
    endproperty
    property p_brk_on;
        $rose(dc_brake_active) |->
            $past(running_frequency) < $past(stop_braking_start_frequency);
    endproperty
    property p_brk_i;
        dc_brake_active && $stable(stop_braking_current)
            |-> dc_brake_current == stop_braking_current;
    endproperty
    property p_pulse;
        plc_resume_tracking == $fell(plc_pause);
    endproperty
    a_cfg: assert property (p_cfg) else $error("functions live");
    a_code: assert property (p_code) else $error("fault code");
    a_spd: assert property (p_spd) else $error("speed gate");
    a_upd: assert property (p_upd) else $error("updown gate");
    a_aux: assert property (p_aux) else $error("aux gate");
    a_fmain: assert property (p_fmain) else $error("main gate");
    a_both: assert property (p_both) else $error("both forced");
    a_brk_on: assert property (p_brk_on) else $error("brake on");
    a_brk_i: assert property (p_brk_i) else $error("brake amps");
    a_pulse: assert property (p_pulse) else $error("resume");
    // Main scenarios reached
    c_cfg: cover property (config_error);
    c_brk: cover property ($rose(dc_brake_active));
    c_res: cover property (plc_resume_tracking);
endmodule // itfd_props

// File: test/itfd_switches.sv
`timescale 1ns/1ps
// Contact bank standing in for switches or the elevator controller
module itfd_switches (
    input wire clk,
    input wire [7:0] want,
    output reg [7:0] terminal_in
);
    // Contacts follow the wanted levels at the rising edge; closed reads high
    always @(posedge clk) begin
        terminal_in <= want;
    end
endmodule // itfd_switches
